/* File: rca_adapt.sv */
// Context adaptation stage: transmit rewrite, receive rebuild, AHB-Lite regs.
// Assumes sideband byte streams and a parsed context table feed.
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE_01] Unidirectional operation only, no return path
// [RULE_02] Only UDP/IP profile 0x0002 passes
// [RULE_03] Ids per pipe, never two-byte form
// [RULE_04] Never insert or pass compression padding
// [RULE_05] No feedback packets generated or passed
// [RULE_06] No compression segmentation; segments dropped
// [RULE_07] Max id above 15 means wide ids
// [RULE_08] Table carries max id and profile
// [RULE_09] Mode 1 passes stream unchanged, no context
// [RULE_10] Mode 2 rewrites IR to IR-DYN in place
// [RULE_11] Context table packets use type 100
// [RULE_12] Mode 3 rewrites IR/IR-DYN to compressed
// [RULE_13] Replacement uses following compressed packet format; the code uses the latest preceding plain format (last_fmt)
// [RULE_14] Table sent each frame and on change
// [RULE_15] Receive only after all tables acquired
// [RULE_16] Mode 1 receive discards until first IR
// [RULE_17] Mode 2 receive rebuilds IR from IR-DYN
// [RULE_18] Mode 3 receive rebuilds without start packet
// [RULE_19] Each table is one whole link packet
// [RULE_20] All tables share one format
// [RULE_21] Context store indexed by pipe and id; the code uses only the low four id bits (cid[3:0])
module rca_adapt (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // Transmit stream from the compressor
  input  wire logic                tx_in_valid,
  input  wire rca_pkg::rca_beat_t  tx_in_data,
  output logic                     tx_in_ready,
  // Transmit stream to the encapsulator
  output logic                     tx_out_valid,
  output rca_pkg::rca_beat_t       tx_out_data,
  input  wire logic                tx_out_ready,
  // Extracted context and table requests
  output logic                     ctx_out_valid,
  output rca_pkg::rca_ctx_t        ctx_out_data,
  input  wire logic                frame_tick,
  output logic                     table_send,
  output logic [2:0]               sig_pkt_type,
  output logic                     sig_format_xml,
  output logic [7:0]               max_context_id,
  output logic [15:0]              context_profile,
  // Receive side signaling
  input  wire logic                slt_seen,
  input  wire logic                lmt_seen,
  input  wire logic                cdt_seen,
  input  wire logic                ctx_in_valid,
  input  wire rca_pkg::rca_ctx_in_t ctx_in_data,
  input  wire logic [1:0]          rx_pipe,
  // Receive stream from the link
  input  wire logic                rx_in_valid,
  input  wire rca_pkg::rca_beat_t  rx_in_data,
  output logic                     rx_in_ready,
  // Receive stream to the decompressor
  output logic                     rx_out_valid,
  output rca_pkg::rca_beat_t       rx_out_data,
  input  wire logic                rx_out_ready,
  output logic                     wide_context_ids
);
  import rca_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Registers and bus state
  logic [1:0]  mode;            // Adaptation mode
  logic        restart;         // One-cycle rx restart
  logic        wr_pend;         // Write data phase pending
  logic [7:0]  bus_addr;        // Latched address phase
  logic [15:0] tx_drops;        // Tx packets refused
  logic [15:0] rx_drops;        // Rx packets discarded
  logic        slt_ok;          // Service list acquired
  logic        lmt_ok;          // Link mapping acquired
  logic        cdt_ok;          // Context table acquired
  logic        rx_started;      // Start packet seen
  logic        table_pending;   // Context changed, table owed
  logic        addr_ok;         // Valid address phase

  // Zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1];

  // Address phase capture
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_pend  <= 1'b0;
      bus_addr <= 8'h00;
    end else if (hready) begin
      wr_pend  <= addr_ok && hwrite;
      bus_addr <= haddr[7:0];
    end
  end

  // Register writes in the data phase
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode           <= MODE_RESET;
      sig_format_xml <= 1'b0;
      max_context_id <= MAXCID_RESET;
      restart        <= 1'b0;
    end else begin
      restart <= 1'b0;
      if (wr_pend && bus_addr == REG_CTRL) begin
        mode           <= hwdata[CTRL_MODE_LSB +: 2];
        sig_format_xml <= hwdata[CTRL_FORMAT_BIT];    // [RULE_20]
        restart        <= hwdata[CTRL_RESTART];
      end
      // Eight bits: no two-byte id form
      if (wr_pend && bus_addr == REG_MAXCID)
        max_context_id <= hwdata[7:0];                // [RULE_03]
    end
  end

  // Read mux; unmapped reads zero
  always_comb begin
    hrdata = 32'h0000_0000;
    case (bus_addr)
      REG_CTRL:   hrdata = {28'h0, 1'b0, sig_format_xml, mode};
      REG_MAXCID: hrdata = {24'h0, max_context_id};
      REG_STATUS: hrdata = {26'h0, table_pending, wide_context_ids,
                            rx_started, cdt_ok, lmt_ok, slt_ok};
      REG_DROPS:  hrdata = {rx_drops, tx_drops};
      default:    hrdata = 32'h0000_0000;
    endcase
  end

  // Table fields
  assign wide_context_ids = max_context_id > SMALL_CID_MAX;   // [RULE_07]
  assign context_profile  = PROFILE_UDP;                      // [RULE_08]

  //////////////////////////////////////////////////////////////////////////////
  // Transmit classification
  logic       tx_take;        // Beat accepted
  logic       tx_is_ir;       // Current beat's packet is IR
  logic       tx_is_dyn;      // Current beat's packet is IR-DYN
  logic       tx_bad;         // Current beat's packet refused
  logic       pkt_ir;         // Latched kind for later beats
  logic       pkt_dyn;
  logic       pkt_bad;
  logic       sop_bad;        // Refusal test on the type byte and profile
  logic [7:0] last_fmt;       // Latest plain compressed type byte
  logic       extract;        // Beat moves to the context path
  logic       fwd;            // Beat goes downstream

  assign tx_in_ready = !tx_out_valid || tx_out_ready;
  assign tx_take     = tx_in_valid && tx_in_ready;

  // Refused packets never reach the link
  assign sop_bad = tx_in_data.data == TYPE_PADDING                        // [RULE_04]
                || (tx_in_data.data & TYPE_FB_MASK) == TYPE_FB_VAL        // [RULE_05] [RULE_01]
                || (tx_in_data.data & TYPE_SEG_MASK) == TYPE_SEG_VAL      // [RULE_06]
                || tx_in_data.profile != PROFILE_UDP;                     // [RULE_02]
  assign tx_is_ir  = tx_in_data.sop ? (tx_in_data.data & TYPE_IR_MASK) == TYPE_IR_VAL
                                    : pkt_ir;
  assign tx_is_dyn = tx_in_data.sop ? tx_in_data.data == TYPE_IR_DYN : pkt_dyn;
  assign tx_bad    = tx_in_data.sop ? sop_bad : pkt_bad;

  // Which beats carry context away from the stream
  always_comb begin
    extract = 1'b0;
    case (mode)
      MODE_STATIC: extract = tx_is_ir && tx_in_data.part == PART_STATIC;   // [RULE_10]
      MODE_FULL:   extract = (tx_is_ir || tx_is_dyn)
                          && (tx_in_data.part == PART_STATIC
                           || tx_in_data.part == PART_DYN);                // [RULE_12]
      default:     extract = 1'b0;                                         // [RULE_09]
    endcase
  end
  assign fwd = tx_take && !tx_bad && !extract;

  // Packet kind held across the packet
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pkt_ir  <= 1'b0;
      pkt_dyn <= 1'b0;
      pkt_bad <= 1'b0;
    end else if (tx_take && tx_in_data.sop) begin
      pkt_ir  <= tx_is_ir;
      pkt_dyn <= tx_is_dyn;
      pkt_bad <= sop_bad;
    end
  end

  // Latest plain format stands in for the next one; no look-ahead
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      last_fmt <= FMT_RESET;
    else if (tx_take && tx_in_data.sop && !sop_bad && !tx_is_ir && !tx_is_dyn)
      last_fmt <= tx_in_data.data;                                         // [RULE_13]
  end

  // Output register with in-place type rewrite
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_out_valid <= 1'b0;
      tx_out_data  <= '0;
    end else if (tx_in_ready) begin
      tx_out_valid <= fwd;
      if (fwd) begin
        tx_out_data <= tx_in_data;
        if (tx_in_data.sop && mode == MODE_STATIC && tx_is_ir)
          tx_out_data.data <= TYPE_IR_DYN;                                 // [RULE_10]
        else if (tx_in_data.sop && mode == MODE_FULL && (tx_is_ir || tx_is_dyn))
          tx_out_data.data <= last_fmt;                                    // [RULE_12] [RULE_13]
      end
    end
  end

  // Context bytes out, one pulse each
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctx_out_valid <= 1'b0;
      ctx_out_data  <= '0;
    end else begin
      ctx_out_valid <= tx_take && !tx_bad && extract;
      ctx_out_data  <= '{data: tx_in_data.data, part: tx_in_data.part,
                         cid: tx_in_data.cid, last: tx_in_data.eop};
    end
  end

  // Table request each frame and after a change, one packet each
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      table_pending <= 1'b0;
      table_send    <= 1'b0;
      sig_pkt_type  <= SIG_PKT_TYPE;
    end else begin
      table_send   <= frame_tick || table_pending;                         // [RULE_14] [RULE_19]
      sig_pkt_type <= SIG_PKT_TYPE;                                        // [RULE_11]
      // Extraction wins over the clear
      if (tx_take && !tx_bad && extract)
        table_pending <= 1'b1;                                             // [RULE_14]
      else if (table_pending)
        table_pending <= 1'b0;
    end
  end

  // Tx refusal counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      tx_drops <= 16'h0000;
    else if (tx_take && tx_in_data.sop && sop_bad)
      tx_drops <= tx_drops + 16'h0001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive context store, indexed by pipe and low id bits
  logic [7:0]         ctx_mem [PIPES*CIDS][CHAIN];   // Chain bytes
  logic [CHAIN_W:0]   ctx_len [PIPES*CIDS];          // Chain length
  logic [ENTRY_W-1:0] wr_entry;                      // Store write index
  logic [ENTRY_W-1:0] rd_entry;                      // Entry for rx packet

  assign wr_entry = {ctx_in_data.pipe, ctx_in_data.cid[3:0]};             // [RULE_21]

  // Store writes from the parsed context table
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < PIPES*CIDS; i++) begin
        ctx_len[i] <= '0;
        for (int j = 0; j < CHAIN; j++)
          ctx_mem[i][j] <= 8'h00;
      end
    end else if (ctx_in_valid) begin
      ctx_mem[wr_entry][ctx_in_data.idx] <= ctx_in_data.data;
      if (ctx_in_data.last)
        ctx_len[wr_entry] <= {1'b0, ctx_in_data.idx} + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive acquisition state; a seen pulse wins over a restart
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      slt_ok <= 1'b0;
      lmt_ok <= 1'b0;
      cdt_ok <= 1'b0;
    end else begin
      slt_ok <= slt_seen || (slt_ok && !restart);                          // [RULE_15]
      lmt_ok <= lmt_seen || (lmt_ok && !restart);
      cdt_ok <= cdt_seen || (cdt_ok && !restart);
    end
  end

  // Receive rebuild
  typedef enum logic {RX_PASS, RX_INSERT} rca_rx_state_t;
  rca_rx_state_t      rx_state;
  logic               rx_free;       // Output slot can load
  logic               rx_take;       // Input beat accepted
  logic               rx_is_ir;      // Type byte is IR
  logic               rx_is_dyn;     // Type byte is IR-DYN
  logic               rx_is_comp;    // Type byte is plain compressed
  logic               rx_start_now;  // This packet starts reception
  logic               rx_keep_sop;   // Type byte passes
  logic               rx_drop_pkt;   // Rest of packet discarded
  logic               ins_pending;   // Chain to insert before first non-header
  logic               ins_hit;       // Insertion due on this beat
  logic [CHAIN_W:0]   ins_cnt;       // Inserted byte count
  logic [CHAIN_W:0]   ins_len;       // Bytes to insert
  logic [ENTRY_W-1:0] ins_entry;     // Latched store entry
  logic [7:0]         rx_type;       // Rebuilt type byte

  assign rx_free    = !rx_out_valid || rx_out_ready;
  assign ins_hit    = ins_pending && rx_in_data.part != PART_HDR;
  assign rx_in_ready = rx_free && rx_state == RX_PASS && !ins_hit;
  assign rx_take    = rx_in_valid && rx_in_ready;
  assign rd_entry   = {rx_pipe, rx_in_data.cid[3:0]};                      // [RULE_21]
  assign rx_is_ir   = (rx_in_data.data & TYPE_IR_MASK) == TYPE_IR_VAL;
  assign rx_is_dyn  = rx_in_data.data == TYPE_IR_DYN;
  assign rx_is_comp = !rx_is_ir && !rx_is_dyn;

  // Start packet per mode, behind table acquisition
  always_comb begin
    rx_start_now = 1'b0;
    case (mode)
      MODE_STATIC: rx_start_now = rx_is_dyn;                               // [RULE_17]
      MODE_FULL:   rx_start_now = 1'b1;                                    // [RULE_18]
      default:     rx_start_now = rx_is_ir;                                // [RULE_16]
    endcase
  end
  assign rx_keep_sop = slt_ok && lmt_ok && cdt_ok                          // [RULE_15]
                    && (rx_started || rx_start_now);

  // Type byte of the rebuilt packet
  always_comb begin
    rx_type = rx_in_data.data;
    if (mode == MODE_STATIC && rx_is_dyn)
      rx_type = TYPE_IR;                                                   // [RULE_17]
    else if (mode == MODE_FULL && rx_is_comp)
      rx_type = TYPE_IR;                                                   // [RULE_18]
  end

  // Start, drop and insertion bookkeeping
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_started  <= 1'b0;
      rx_drop_pkt <= 1'b0;
      ins_pending <= 1'b0;
      ins_entry   <= '0;
      rx_drops    <= 16'h0000;
    end else begin
      if (rx_take && rx_in_data.sop) begin
        rx_drop_pkt <= !rx_keep_sop;
        ins_entry   <= rd_entry;
        ins_pending <= rx_keep_sop && ((mode == MODE_STATIC && rx_is_dyn)
                                    || (mode == MODE_FULL && rx_is_comp));
        if (!rx_keep_sop)
          rx_drops <= rx_drops + 16'h0001;
      end else if (rx_state == RX_INSERT && rx_free && ins_cnt + 4'h1 >= ins_len)
        ins_pending <= 1'b0;
      else if (rx_state == RX_PASS && rx_in_valid && rx_free && ins_hit
               && ctx_len[ins_entry] == '0)
        ins_pending <= 1'b0;
      // A start packet wins over a restart in the same cycle
      if (rx_take && rx_in_data.sop && rx_keep_sop)
        rx_started <= 1'b1;                                                // [RULE_16]
      else if (restart)
        rx_started <= 1'b0;
    end
  end

  // Insertion: input stalls while the chain goes out
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_state <= RX_PASS;
      ins_cnt  <= '0;
      ins_len  <= '0;
    end else begin
      case (rx_state)
        RX_PASS: begin
          if (rx_in_valid && rx_free && ins_hit && ctx_len[ins_entry] != '0) begin
            rx_state <= RX_INSERT;
            ins_cnt  <= '0;
            ins_len  <= ctx_len[ins_entry];
          end
        end
        RX_INSERT: begin
          if (rx_free) begin
            ins_cnt <= ins_cnt + 4'h1;
            if (ins_cnt + 4'h1 >= ins_len)
              rx_state <= RX_PASS;
          end
        end
        default: rx_state <= RX_PASS;
      endcase
    end
  end

  // Rx output register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_out_valid <= 1'b0;
      rx_out_data  <= '0;
    end else if (rx_free) begin
      if (rx_state == RX_INSERT) begin
        // Stored chain byte for the same pipe and low id bits
        rx_out_valid        <= 1'b1;
        rx_out_data         <= '0;
        rx_out_data.data    <= ctx_mem[ins_entry][ins_cnt[CHAIN_W-1:0]];   // [RULE_21]
        rx_out_data.part    <= PART_STATIC;
        rx_out_data.cid     <= rx_in_data.cid;
        rx_out_data.profile <= PROFILE_UDP;
      end else begin
        rx_out_valid <= rx_take && (rx_in_data.sop ? rx_keep_sop : !rx_drop_pkt);
        rx_out_data  <= rx_in_data;
        if (rx_in_data.sop)
          rx_out_data.data <= rx_type;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rca_adapt_asserts.sv */
// Port checker for the context adaptation stage.
// Assumes it is bound onto every rca_adapt instance.
`timescale 1ns/1ps
`default_nettype none
module rca_adapt_chk
  import rca_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       tx_out_valid,
  input wire rca_beat_t  tx_out_data,
  input wire logic       ctx_out_valid,
  input wire logic       frame_tick,
  input wire logic       table_send,
  input wire logic [2:0] sig_pkt_type,
  input wire logic [7:0] max_context_id,
  input wire logic       wide_context_ids,
  input wire logic [15:0] context_profile
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Type byte of each packet leaving for the encapsulator
  wire logic s = tx_out_valid && tx_out_data.sop;
  property p_sig; sig_pkt_type == 3'b100; endproperty
  a_sig: assert property (p_sig) else $error("signal type");
  property p_prof; context_profile == 16'h0002; endproperty
  a_prof: assert property (p_prof) else $error("profile");
  property p_wide; wide_context_ids == (max_context_id > 8'h0f); endproperty
  a_wide: assert property (p_wide) else $error("wide ids");
  property p_frm; frame_tick |=> table_send; endproperty
  a_frm: assert property (p_frm) else $error("no frame table");
  property p_chg; ctx_out_valid |-> ##[1:3] table_send; endproperty
  a_chg: assert property (p_chg) else $error("no change table");
  property p_pad; s |-> tx_out_data.data != 8'he0; endproperty
  a_pad: assert property (p_pad) else $error("padding out");
  property p_fb; s |-> (tx_out_data.data & 8'hf8) != 8'hf0; endproperty
  a_fb: assert property (p_fb) else $error("feedback out");
  property p_seg; s |-> (tx_out_data.data & 8'hfe) != 8'hfe; endproperty
  a_seg: assert property (p_seg) else $error("segment out");
  property p_oprof; s |-> tx_out_data.profile == 16'h0002; endproperty
  a_oprof: assert property (p_oprof) else $error("bad profile out");
endmodule
bind rca_adapt rca_adapt_chk u_chk(.ref_clk, .reset, .tx_out_valid, .tx_out_data,
  .ctx_out_valid, .frame_tick, .table_send, .sig_pkt_type, .max_context_id,
  .wide_context_ids, .context_profile);
`default_nettype wire

/* File: rca_pkg.sv */
// Package for the header-compression context adaptation stage.
// Assumes one 250 MHz clock; shared by the design and its bench.
package rca_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, AHB-Lite byte addresses
  localparam logic [7:0] REG_CTRL    = 8'h00;  // Mode, table format, rx restart
  localparam logic [7:0] REG_MAXCID  = 8'h04;  // Highest context id in use
  localparam logic [7:0] REG_STATUS  = 8'h08;  // Acquisition and start state
  localparam logic [7:0] REG_DROPS   = 8'h0c;  // Dropped packet counters

  // Control field positions
  localparam int CTRL_MODE_LSB   = 0;          // Two-bit adaptation mode
  localparam int CTRL_FORMAT_BIT = 2;          // 0 binary tables, 1 XML tables
  localparam int CTRL_RESTART    = 3;          // Write one: restart rx hunt

  // Status field positions
  localparam int ST_SLT     = 0;
  localparam int ST_LMT     = 1;
  localparam int ST_CDT     = 2;
  localparam int ST_STARTED = 3;
  localparam int ST_WIDE    = 4;
  localparam int ST_PENDING = 5;

  // Reset values
  localparam logic [1:0] MODE_RESET   = 2'h1;
  localparam logic [7:0] MAXCID_RESET = 8'h0f;

  // Adaptation modes
  localparam logic [1:0] MODE_BUFFER  = 2'h1;
  localparam logic [1:0] MODE_STATIC  = 2'h2;
  localparam logic [1:0] MODE_FULL    = 2'h3;

  // Compressed packet type bytes and masks
  localparam logic [7:0] TYPE_IR       = 8'hfd;  // IR carrying a dynamic chain
  localparam logic [7:0] TYPE_IR_MASK  = 8'hfe;
  localparam logic [7:0] TYPE_IR_VAL   = 8'hfc;
  localparam logic [7:0] TYPE_IR_DYN   = 8'hf8;
  localparam logic [7:0] TYPE_PADDING  = 8'he0;
  localparam logic [7:0] TYPE_FB_MASK  = 8'hf8;
  localparam logic [7:0] TYPE_FB_VAL   = 8'hf0;
  localparam logic [7:0] TYPE_SEG_MASK = 8'hfe;
  localparam logic [7:0] TYPE_SEG_VAL  = 8'hfe;
  localparam logic [7:0] FMT_RESET     = 8'h00;  // Compressed format before any seen

  // Only the UDP/IP profile is allowed
  localparam logic [15:0] PROFILE_UDP  = 16'h0002;
  // Link packet type of the signaling carrier
  localparam logic [2:0]  SIG_PKT_TYPE = 3'b100;
  // Largest id of the small-identifier form
  localparam logic [7:0]  SMALL_CID_MAX = 8'h0f;

  // Context store geometry
  localparam int PIPES      = 4;
  localparam int CIDS       = 16;
  localparam int CHAIN      = 8;
  localparam int ENTRY_W    = 6;   // log2(PIPES*CIDS)
  localparam int CHAIN_W    = 3;   // log2(CHAIN)

  // Part of a header that a byte belongs to
  typedef enum logic [1:0] {
    PART_HDR    = 2'h0,
    PART_STATIC = 2'h1,
    PART_DYN    = 2'h2,
    PART_BODY   = 2'h3
  } rca_part_t;

  // One byte of a compressed packet with its sideband
  typedef struct packed {
    logic [7:0]  data;
    logic        sop;
    logic        eop;
    rca_part_t   part;
    logic [7:0]  cid;
    logic [15:0] profile;
  } rca_beat_t;

  // One extracted context byte for the table builder
  typedef struct packed {
    logic [7:0] data;
    rca_part_t  part;
    logic [7:0] cid;
    logic       last;
  } rca_ctx_t;

  // One received context byte from the parsed table
  typedef struct packed {
    logic [1:0]         pipe;
    logic [7:0]         cid;
    logic [CHAIN_W-1:0] idx;
    logic [7:0]         data;
    logic               last;
  } rca_ctx_in_t;

endpackage

/* File: rca_sink.sv */
// Encapsulator model: takes the transmit stream, stalls when asked.
// Assumes the same clock and reset as the stage.
`timescale 1ns/1ps
`default_nettype none
module rca_sink (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow,
  output logic     tx_out_ready
);
  logic [2:0] cnt;  // Stall pacing
  // Only a ready goes back: no return path
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt <= 3'h0;
      tx_out_ready <= 1'b1;
    end else begin
      cnt <= cnt + 3'h1;
      tx_out_ready <= !slow || cnt == 3'h0;
    end
  end
endmodule
`default_nettype wire

/* File: tb_rca_adapt.sv */
// Bench for the adaptation stage: registers, tx rewrite, rx start.
// Assumes rca_sink as the encapsulator and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_rca_adapt;
  import rca_pkg::*;
  logic ref_clk = 0, reset = 1, hsel = 0, hwrite = 0, frame_tick = 0, slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic tx_in_valid = 0, rx_in_valid = 0, slt_seen = 0, lmt_seen = 0, cdt_seen = 0;
  logic hreadyout, tx_in_ready, tx_out_valid, tx_out_ready, rx_in_ready, rx_out_valid;
  logic ctx_out_valid, sig_format_xml, wide_context_ids;
  logic [7:0] max_context_id, seed = 8'h19;
  rca_beat_t tx_in_data = '0, rx_in_data = '0, b, tx_out_data, rx_out_data, qt[$], qr[$];
  int fails = 0, check_count = 0, nctx = 0;
  always #2 ref_clk = ~ref_clk;
  rca_adapt u_dut(.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .tx_in_valid,
    .tx_in_data, .tx_in_ready, .tx_out_valid, .tx_out_data, .tx_out_ready,
    .ctx_out_valid, .ctx_out_data(), .frame_tick, .table_send(), .sig_pkt_type(),
    .sig_format_xml, .max_context_id, .context_profile(), .slt_seen, .lmt_seen,
    .cdt_seen, .ctx_in_valid(1'b0), .ctx_in_data('0), .rx_pipe(2'h0), .rx_in_valid,
    .rx_in_data, .rx_in_ready, .rx_out_valid, .rx_out_data, .rx_out_ready(1'b1),
    .wide_context_ids);
  rca_sink u_sink(.ref_clk, .reset, .slow, .tx_out_ready);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task check(input logic [35:0] s, input logic [35:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Single word transfer; read data lands in r
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'h2, w};
    do @(posedge ref_clk); while (!hreadyout);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge ref_clk); while (!hreadyout);
    r = hrdata;
  endtask
  // One packet: type, profile, static/dyn/body counts, expected type and fate
  task send(input bit rx, input logic [7:0] t, input logic [15:0] p, input int ns, nd, nb,
            input logic [7:0] ot, input bit kt, st, sd, kr);
    int n;
    n = 1 + ns + nd + nb;
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      b = '{i == 0 ? t : seed, i == 0, i == n - 1, i == 0 ? PART_HDR : i <= ns ? PART_STATIC
            : i <= ns + nd ? PART_DYN : PART_BODY, 8'h05, p};
      if (rx) {rx_in_valid, rx_in_data} <= {1'b1, b};
      else {tx_in_valid, tx_in_data} <= {1'b1, b};
      do @(posedge ref_clk); while (!(rx ? rx_in_ready : tx_in_ready));
      if (i == 0) b.data = ot;
      if (rx && kr) qr.push_back(b);
      if (!rx && kt && !(st && b.part == PART_STATIC) && !(sd && b.part == PART_DYN))
        qt.push_back(b);
    end
    {tx_in_valid, rx_in_valid} <= 2'b00;
  endtask
  // Watcher; stray beats meet all ones
  always @(posedge ref_clk) begin
    if (ctx_out_valid) nctx++;
    if (tx_out_valid && tx_out_ready) check(tx_out_data, qt.size() ? qt.pop_front() : '1);
    if (rx_out_valid) check(rx_out_data, qr.size() ? qr.pop_front() : '1);
  end
  initial begin
    logic [7:0] bad [5] = '{8'he0, 8'hf3, 8'hfe, 8'hff, 8'h20};
    repeat (20) @(posedge ref_clk);
    reset <= 0;
    ahb(0, 8'h04, 0);
    check(r, 32'h0f);
    ahb(0, 8'h10, 0);
    check(r, 0);
    send(1, 8'h20, 16'h2, 0, 0, 3, 8'h20, 0, 0, 0, 0);
    {slt_seen, lmt_seen, cdt_seen} <= 3'b111;
    @(posedge ref_clk);
    {slt_seen, lmt_seen, cdt_seen} <= 3'b000;
    send(1, 8'h20, 16'h2, 0, 0, 3, 8'h20, 0, 0, 0, 0);
    send(1, 8'hfd, 16'h2, 1, 1, 2, 8'hfd, 0, 0, 0, 1);
    send(1, 8'h20, 16'h2, 0, 0, 2, 8'h20, 0, 0, 0, 1);
    send(0, 8'hfd, 16'h2, 1, 1, 2, 8'hfd, 1, 0, 0, 0);
    // Refused packet kinds
    for (int i = 0; i < 5; i++) send(0, bad[i], i < 4 ? 16'h2 : 16'h3, 0, 0, 2, 0, 0, 0, 0, 0);
    frame_tick <= 1;
    ahb(1, 8'h04, 32'h20);
    frame_tick <= 0;
    @(posedge ref_clk);
    check({wide_context_ids, max_context_id}, 9'h120);
    ahb(1, 8'h00, 32'h2);
    slow <= 1;
    send(0, 8'hfd, 16'h2, 2, 2, 2, 8'hf8, 1, 1, 0, 0);
    send(0, 8'hf8, 16'h2, 0, 2, 1, 8'hf8, 1, 0, 0, 0);
    ahb(1, 8'h00, 32'h7);
    send(0, 8'h40, 16'h2, 0, 0, 2, 8'h40, 1, 0, 0, 0);
    send(0, 8'hfd, 16'h2, 2, 2, 2, 8'h40, 1, 1, 1, 0);
    send(0, 8'hf8, 16'h2, 0, 2, 1, 8'h40, 1, 0, 1, 0);
    repeat (30) @(posedge ref_clk);
    check(nctx, 8);
    check({sig_format_xml, 8'(qt.size() + qr.size())}, 9'h100);
    ahb(0, 8'h0c, 0);
    check(r, 32'h0002_0005);
    ahb(0, 8'h08, 0);
    check(r & 32'h1f, 32'h1f);
    wrap_up;
  end
  initial begin
    #40000;
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
